// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import tif_pkg::*;
  logic              ref_clk  = 1'b0;
  logic              nrst     = 1'b0;
  tif_req_t          bus_req;
  tif_rsp_t          bus_rsp;
  logic [BASE_W-1:0] thumb_sw = BASE_RESET;
  logic              rx_valid = 1'b0;
  logic [DATA_W-1:0] rx_char  = 16'h0000;
  logic              tx_done  = 1'b0;
  logic              tx_valid;
  logic [DATA_W-1:0] tx_char;
  logic [BASE_W-1:0] base_q;
  logic [BASE_W-1:0] m_base   = BASE_RESET;
  logic [BASE_W-1:0] old;
  logic              m_loop   = 1'b0;
  logic [DATA_W-1:0] m_reg [8];
  logic [DATA_W-1:0] d;
  logic [15:0]       seed     = 16'h0035;
  logic              ack;
  logic [DATA_W-1:0] r;
  int                n_errors = 0;
  int                comparisons = 0;
  int                tx_seen  = 0;
  always #2.5 ref_clk = ~ref_clk;
  tif_regsel u_dut (.ref_clk(ref_clk), .nrst(nrst), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .thumb_sw(thumb_sw), .rx_valid(rx_valid), .rx_char(rx_char), .tx_done(tx_done),
    .tx_valid(tx_valid), .tx_char(tx_char), .base_q(base_q));
  tif_cpu u_cpu (.ref_clk(ref_clk), .bus_rsp(bus_rsp), .bus_req(bus_req));
  always @(negedge ref_clk) if (tx_valid === 1'b1) tx_seen++;
  function automatic logic [15:0] lfsr();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : lfsr
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  // odd index writes, even reads; model follows each access
  task automatic acc(input logic [2:0] idx, input logic [DATA_W-1:0] w, input logic [BASE_W-1:0] b);
    logic hit;
    hit = (b == m_base);
    u_cpu.xfer({6'h00, b, idx}, w, ack, r);
    chk({15'h0000, ack}, {15'h0000, hit});
    if (ack === 1'b1) chk(r, (idx[0] || !hit) ? 16'h0000 : m_reg[idx]);
    if (hit && idx == 3'h0) m_reg[2][3] = 1'b0;
    if (hit && idx == 3'h3) m_reg[2][2:0] = w[2:0];
    // test mode loops the written character into the input side
    if (hit && idx == 3'h5 && m_loop) begin
      if (m_reg[2][3]) m_reg[2][5:4] = 2'h3;
      m_reg[0] = w;
      m_reg[2][3] = 1'b1;
    end
    if (hit && idx == 3'h5 && !m_loop) begin
      if (!m_reg[6][3]) m_reg[6][5:4] = 2'h3;
      m_reg[6][3] = 1'b0;
    end
    if (hit && idx == 3'h7) m_reg[6][2:0] = w[2:0];
    if (hit && idx == 3'h7) m_loop = w[CMD_TEST];
    // device clear empties both channels; commands stay zero
    if (hit && idx == 3'h3 && w[CMD_CLEAR]) begin
      m_reg = '{default: 16'h0000};
      m_reg[6] = 16'h0008;
      m_loop = 1'b0;
    end
  endtask : acc
  initial begin
    m_reg = '{default: 16'h0000};
    m_reg[6] = 16'h0008;
    repeat (8) @(negedge ref_clk);
    nrst = 1'b1;
    acc(3'h6, 16'h0000, m_base);
    acc(3'h4, 16'h0000, m_base);
    acc(3'h1, lfsr(), m_base);
    acc(3'h6, 16'h0000, m_base + 7'h01);
    u_cpu.xfer(16'h04c6, 16'h0000, ack, r);
    chk({15'h0000, ack}, 16'h0000);
    acc(3'h7, 16'h0004, m_base);
    acc(3'h6, 16'h0000, m_base);
    d = lfsr();
    acc(3'h5, d, m_base);
    repeat (4) @(negedge ref_clk);
    chk(tx_char, d);
    chk(tx_seen[15:0], 16'h0001);
    acc(3'h6, 16'h0000, m_base);
    tx_done = 1'b1;
    @(negedge ref_clk);
    tx_done = 1'b0;
    m_reg[6][3] = 1'b1;
    acc(3'h3, 16'h0004, m_base);
    rx_char = lfsr();
    rx_valid = 1'b1;
    @(negedge ref_clk);
    rx_valid = 1'b0;
    m_reg[0] = rx_char;
    m_reg[2][3] = 1'b1;
    acc(3'h2, 16'h0000, m_base);
    acc(3'h0, 16'h0000, m_base);
    acc(3'h2, 16'h0000, m_base);
    acc(3'h6, 16'h0000, m_base);
    // two arrivals with no read in between: overrun
    repeat (2) begin
      rx_char = lfsr();
      rx_valid = 1'b1;
      @(negedge ref_clk);
    end
    rx_valid = 1'b0;
    m_reg[0] = rx_char;
    m_reg[2][5:3] = 3'h7;
    acc(3'h2, 16'h0000, m_base);
    acc(3'h0, 16'h0000, m_base);
    acc(3'h7, 16'h000c, m_base);
    d = lfsr();
    acc(3'h5, d, m_base);
    acc(3'h6, 16'h0000, m_base);
    acc(3'h0, 16'h0000, m_base);
    chk(tx_seen[15:0], 16'h0001);
    acc(3'h3, 16'h0010, m_base);
    acc(3'h2, 16'h0000, m_base);
    acc(3'h6, 16'h0000, m_base);
    chk(tx_char, 16'h0000);
    d = lfsr();
    thumb_sw = d[6:0] | 7'h01;
    repeat (8) @(negedge ref_clk);
    old = m_base;
    m_base = thumb_sw;
    chk({9'h000, base_q}, {9'h000, m_base});
    acc(3'h6, 16'h0000, old);
    acc(3'h6, 16'h0000, m_base);
    wrap_up();
  end
  initial begin
    #20000;
    n_errors++;
    wrap_up();
  end
endmodule : tb_top
bind tif_regsel tif_regsel_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .bus_req(bus_req), .bus_rsp(bus_rsp),
  .thumb_sw(thumb_sw), .tx_char(tx_char), .base_q(base_q));

// ### tif_chan.sv
`timescale 1ns/10ps
module tif_chan #(
  parameter logic RDY_RST = 1'b0
) (
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  input  wire logic                       cmd_we,
  input  wire logic [tif_pkg::DATA_W-1:0] cmd_wdata,
  input  wire logic                       dev_clear,
  input  wire logic                       rdy_set,
  input  wire logic                       rdy_clr,
  input  wire logic                       err_set,
  output logic      [tif_pkg::DATA_W-1:0] cmd_q,
  output logic      [tif_pkg::DATA_W-1:0] cond
);
  import tif_pkg::*;

  logic rdy_q;
  logic err_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst || dev_clear) begin
      cmd_q <= WORD_RESET;
    end else if (cmd_we) begin
      cmd_q <= cmd_wdata; // R6
    end
  end

  // set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge ref_clk) begin
    if (!nrst || dev_clear) begin
      rdy_q <= RDY_RST;
    end else if (rdy_set) begin
      rdy_q <= 1'b1;
    end else if (rdy_clr) begin
      rdy_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst || dev_clear) begin
      err_q <= 1'b0;
    end else if (err_set) begin
      err_q <= 1'b1;
    end
  end

  always_comb begin
    cond                  = WORD_RESET;
    cond[CMD_ACTIVATE:0]  = cmd_q[CMD_ACTIVATE:0]; // R7
    cond[COND_READY]      = rdy_q; // R7
    cond[COND_ERR_ANY]    = err_q; // R7
    cond[COND_OVERRUN]    = err_q;
  end

endmodule : tif_chan

// ### tif_cpu.sv
`timescale 1ns/10ps
module tif_cpu (
  input  wire logic              ref_clk,
  input  wire tif_pkg::tif_rsp_t bus_rsp,
  output tif_pkg::tif_req_t      bus_req
);
  import tif_pkg::*;
  initial bus_req = '0;
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w,
                      output logic ack, output logic [DATA_W-1:0] r);
    @(negedge ref_clk);
    bus_req = '{strobe: 1'b1, addr: a, wdata: w};
    @(posedge ref_clk);
    @(negedge ref_clk);
    ack = bus_rsp.ack;
    r   = bus_rsp.rdata;
    // released lines show the inverse so stale values never pass
    bus_req = '{strobe: 1'b0, addr: ~a, wdata: ~w};
  endtask : xfer
endmodule : tif_cpu

// ### tif_pkg.sv
package tif_pkg;

  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned IDX_W      = 3;
  localparam int unsigned BASE_W     = 7;
  localparam int unsigned BASE_LSB   = 3;
  localparam int unsigned AREA_LSB   = 10;
  localparam int unsigned SYNC_DEPTH = 3;

  // register indices inside one block of eight
  localparam logic [IDX_W-1:0] IDX_IN_CHAR  = 3'h0;
  localparam logic [IDX_W-1:0] IDX_IN_COND  = 3'h2;
  localparam logic [IDX_W-1:0] IDX_IN_CMD   = 3'h3;
  localparam logic [IDX_W-1:0] IDX_OUT_CHAR = 3'h5;
  localparam logic [IDX_W-1:0] IDX_OUT_COND = 3'h6;
  localparam logic [IDX_W-1:0] IDX_OUT_CMD  = 3'h7;

  // command bit positions
  localparam int unsigned CMD_IRQ_RDY  = 0;
  localparam int unsigned CMD_IRQ_ERR  = 1;
  localparam int unsigned CMD_ACTIVATE = 2;
  localparam int unsigned CMD_TEST     = 3;
  localparam int unsigned CMD_CLEAR    = 4;

  // condition bit positions
  localparam int unsigned COND_READY   = 3;
  localparam int unsigned COND_ERR_ANY = 4;
  localparam int unsigned COND_OVERRUN = 5;

  // reset values; base 300 octal is block 0x18
  localparam logic [BASE_W-1:0] BASE_RESET = 7'h18;
  localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;
  localparam logic              IN_RDY_RESET  = 1'b0;
  localparam logic              OUT_RDY_RESET = 1'b1;

  typedef struct packed {
    logic              strobe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tif_req_t;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] rdata;
  } tif_rsp_t;

  typedef struct packed {
    logic             hit;
    logic             wr;
    logic [IDX_W-1:0] idx;
  } tif_dec_t;

  // splits a device register address into block match, direction and index
  function automatic tif_dec_t tif_decode(input logic [ADDR_W-1:0] addr,
                                          input logic [BASE_W-1:0] base);
    tif_dec_t d;
    d.hit = (addr[ADDR_W-1:AREA_LSB] == '0) && (addr[AREA_LSB-1:BASE_LSB] == base);
    d.wr  = addr[0];
    d.idx = addr[IDX_W-1:0];
    return d;
  endfunction : tif_decode

endpackage : tif_pkg

// ### tif_regsel.sv
// Functional notes
// R1 - one block of consecutive addresses, 4 to 16 registers; here eight.
// R2 - address is base plus index; answer only inside own block.
// R3 - base device number comes from a module thumbwheel.
// R4 - decoding uses only the thumbwheel number, never the bus slot.
// R5 - base 300 octal answers addresses 300 to 307 octal.
// R6 - control registers accept writes only, on both channels.
// R7 - status registers are read only: ready, busy, error of the channel. Here ready, error, overrun and command bits 2:0; no busy bit.
// R8 - output data is write only, input data is read only.
// R9 - every channel has control, status and data registers.
// R10 - one-channel layout: control 3, status 2, data 1, loop-back 0.
// R11 - two-channel layout: in data 0, status 2, control 3; out 5, 6, 7.
// R12 - input and output channels have independent register sets.
// R13 - both channels transfer at the same time.
// R14 - dma interfaces have 8 to 16 registers and no data register.
// R15 - no two installed interfaces may decode the same block.
// R16 - each index is distinct and tied to one function.
// R17 - address bit 0 gives direction: even reads, odd writes.
// R18 - decoding limited to the low 1K area, 0 to 1777 octal.
// R19 - unimplemented index in that direction changes nothing and reads zero.
`timescale 1ns/10ps
module tif_regsel (
  input  wire logic                       ref_clk,
  input  wire logic                       nrst,
  input  wire tif_pkg::tif_req_t          bus_req,
  output tif_pkg::tif_rsp_t               bus_rsp,
  input  wire logic [tif_pkg::BASE_W-1:0] thumb_sw,
  input  wire logic                       rx_valid,
  input  wire logic [tif_pkg::DATA_W-1:0] rx_char,
  input  wire logic                       tx_done,
  output logic                            tx_valid,
  output logic      [tif_pkg::DATA_W-1:0] tx_char,
  output logic      [tif_pkg::BASE_W-1:0] base_q
);
  import tif_pkg::*;

  tif_dec_t          dec;
  logic              take;
  logic              rd_hit;
  logic              wr_hit;
  logic              in_cmd_we;
  logic              out_cmd_we;
  logic              out_char_we;
  logic              in_char_rd;
  logic              dev_clear;
  logic [DATA_W-1:0] in_cmd;
  logic [DATA_W-1:0] out_cmd;
  logic [DATA_W-1:0] in_cond;
  logic [DATA_W-1:0] out_cond;
  logic              in_active;
  logic              out_active;
  logic              loop_mode;
  logic              in_fill;
  logic              in_rdy;
  logic              out_rdy;
  logic              launch;
  logic [DATA_W-1:0] in_char_q;
  logic [DATA_W-1:0] rd_mux;
  logic              sent_q;
  logic              ack_q;
  logic [DATA_W-1:0] rdata_q;
  logic              tx_valid_q;
  logic [DATA_W-1:0] tx_char_q;

  // thumbwheel is a pin: synchronised, no slot input exists at all
  tif_sync #(
    .W   (BASE_W),
    .RST (BASE_RESET)
  ) u_thumb (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pin     (thumb_sw),
    .val_q   (base_q)
  ); // R3 R4

  // block of eight; uniqueness across cards is the installer's duty
  always_comb begin
    dec    = tif_decode(bus_req.addr, base_q); // R1 R2 R5 R14 R15 R18
    take   = bus_req.strobe && dec.hit; // R2
    wr_hit = take && dec.wr; // R17
    rd_hit = take && !dec.wr; // R17
  end

  always_comb begin
    in_cmd_we   = wr_hit && (dec.idx == IDX_IN_CMD); // R11 R16
    out_cmd_we  = wr_hit && (dec.idx == IDX_OUT_CMD); // R11 R16
    out_char_we = wr_hit && (dec.idx == IDX_OUT_CHAR); // R8 R11
    in_char_rd  = rd_hit && (dec.idx == IDX_IN_CHAR); // R8 R11
    // clear from the input command resets both channels
    dev_clear   = in_cmd_we && bus_req.wdata[CMD_CLEAR];
  end

  always_comb begin
    in_active  = in_cmd[CMD_ACTIVATE];
    out_active = out_cmd[CMD_ACTIVATE];
    loop_mode  = out_cmd[CMD_TEST];
    // offline test loops written characters back to the input side
    in_fill    = loop_mode ? out_char_we : (rx_valid && in_active);
    in_rdy     = in_cond[COND_READY];
    out_rdy    = out_cond[COND_READY];
    launch     = out_active && !loop_mode && !out_rdy && !sent_q;
  end

  // input channel: ready set by arrival, cleared by reading the data
  tif_chan #(
    .RDY_RST (IN_RDY_RESET)
  ) u_in (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .cmd_we    (in_cmd_we),
    .cmd_wdata (bus_req.wdata),
    .dev_clear (dev_clear),
    .rdy_set   (in_fill),
    .rdy_clr   (in_char_rd),
    .err_set   (in_fill && in_rdy && !in_char_rd),
    .cmd_q     (in_cmd),
    .cond      (in_cond)
  ); // R9 R12

  // output channel: ready means empty; a write outside test mode fills, completion empties
  tif_chan #(
    .RDY_RST (OUT_RDY_RESET)
  ) u_out (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .cmd_we    (out_cmd_we),
    .cmd_wdata (bus_req.wdata),
    .dev_clear (dev_clear),
    .rdy_set   (tx_done || (out_char_we && loop_mode)),
    .rdy_clr   (out_char_we && !loop_mode),
    .err_set   (out_char_we && !out_rdy),
    .cmd_q     (out_cmd),
    .cond      (out_cond)
  ); // R9 R12

  always_ff @(posedge ref_clk) begin
    if (!nrst || dev_clear) begin
      in_char_q <= WORD_RESET;
    end else if (in_fill) begin
      in_char_q <= loop_mode ? bus_req.wdata : rx_char; // R8 R13
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst || dev_clear) begin
      tx_char_q <= WORD_RESET;
    end else if (out_char_we) begin
      tx_char_q <= bus_req.wdata; // R8 R13
    end
  end

  // a character written outside test mode is sent once, when written while active or when activated later
  always_ff @(posedge ref_clk) begin
    if (!nrst || dev_clear) begin
      sent_q <= 1'b0;
    end else if (out_char_we) begin
      sent_q <= 1'b0;
    end else if (launch) begin
      sent_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      tx_valid_q <= 1'b0;
    end else begin
      tx_valid_q <= launch && !out_char_we && !dev_clear;
    end
  end

  // read mux: write-only and missing indices answer zero
  always_comb begin
    rd_mux = WORD_RESET;
    unique case (dec.idx)
      IDX_IN_CHAR:  rd_mux = in_char_q; // R8
      IDX_IN_COND:  rd_mux = in_cond; // R7 R10
      IDX_OUT_COND: rd_mux = out_cond; // R7
      default:      rd_mux = WORD_RESET; // R19
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ack_q   <= 1'b0;
      rdata_q <= WORD_RESET;
    end else begin
      ack_q   <= take; // R2
      rdata_q <= rd_hit ? rd_mux : WORD_RESET; // R19
    end
  end

  always_comb begin
    bus_rsp.ack   = ack_q;
    bus_rsp.rdata = rdata_q;
    tx_valid      = tx_valid_q;
    tx_char       = tx_char_q;
  end

endmodule : tif_regsel

// ### tif_regsel_chk.sv
`timescale 1ns/10ps
module tif_regsel_chk (
  input wire logic                       ref_clk,
  input wire logic                       nrst,
  input wire tif_pkg::tif_req_t          bus_req,
  input wire tif_pkg::tif_rsp_t          bus_rsp,
  input wire logic [tif_pkg::BASE_W-1:0] thumb_sw,
  input wire logic [tif_pkg::DATA_W-1:0] tx_char,
  input wire logic [tif_pkg::BASE_W-1:0] base_q
);
  import tif_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic hit;
  assign hit = bus_req.strobe && bus_req.addr[15:10] == '0 && bus_req.addr[9:3] == base_q;
  property p_ack_hit; hit |=> bus_rsp.ack; endproperty
  a_ack_hit: assert property (p_ack_hit) else $error("no ack on block hit");
  property p_miss_blk; bus_req.strobe && bus_req.addr[9:3] != base_q |=> !bus_rsp.ack; endproperty
  a_miss_blk: assert property (p_miss_blk) else $error("ack outside own block");
  property p_miss_area; bus_req.strobe && bus_req.addr[15:10] != '0 |=> !bus_rsp.ack; endproperty
  a_miss_area: assert property (p_miss_area) else $error("ack above low area");
  property p_wr_zero; hit && bus_req.addr[0] |=> bus_rsp.rdata == '0; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
  property p_gap; hit && bus_req.addr[2:0] == 3'h4 |=> bus_rsp.rdata == '0; endproperty
  a_gap: assert property (p_gap) else $error("empty index read nonzero");
  property p_tx_char; hit && bus_req.addr[2:0] == IDX_OUT_CHAR |=> tx_char == $past(bus_req.wdata); endproperty
  a_tx_char: assert property (p_tx_char) else $error("output char not taken");
  property p_idx1; hit && bus_req.addr[2:0] == 3'h1 |=> $stable(tx_char); endproperty
  a_idx1: assert property (p_idx1) else $error("empty index write changed state");
  // sync chain needs a few edges, so only a settled thumbwheel is judged
  property p_base; (nrst && $stable(thumb_sw))[*6] |-> base_q == thumb_sw; endproperty
  a_base: assert property (p_base) else $error("base not from thumbwheel");
endmodule : tif_regsel_chk

// ### tif_sync.sv
`timescale 1ns/10ps
module tif_sync #(
  parameter int unsigned           W   = 7,
  parameter logic        [W-1:0]   RST = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] val_q
);
  import tif_pkg::*;

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a new setting counts only once two later stages agree
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      val_q <= RST;
    end else if (s2_q == s3_q) begin
      val_q <= s3_q;
    end
  end

endmodule : tif_sync
